// >>> pkg/omc_pkg.sv
/*
  Constants and types for the operating mode controller.
  Assumes a 40 MHz core clock and a decoded debug command code from the serial receiver.
*/
package omc_pkg;

  // ==========================================================================
  // Clock and link timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned BIT_CYCLES      = 16;
  localparam int unsigned BIT_CNT_W       = 4;
  localparam int unsigned BITS_PER_FRAME  = 8;
  localparam int unsigned FRAME_CNT_W     = 3;

  // ==========================================================================
  // Reset vector
  // ==========================================================================
  localparam logic [15:0] VEC_HI_ADDR     = 16'hFFFE;
  localparam logic [15:0] VEC_LO_ADDR     = 16'hFFFF;

  // ==========================================================================
  // Debug command codes (one byte each)
  // ==========================================================================
  localparam logic [7:0] CMD_BACKGROUND   = 8'h90;
  localparam logic [7:0] CMD_RESUME       = 8'h08;
  localparam logic [7:0] CMD_TRACE        = 8'h10;
  localparam logic [7:0] CMD_MEM_READ     = 8'hE0;
  localparam logic [7:0] CMD_MEM_WRITE    = 8'hC0;
  localparam logic [7:0] CMD_MEM_READ_ST  = 8'hE1;
  localparam logic [7:0] CMD_MEM_WRITE_ST = 8'hC1;
  localparam logic [7:0] CMD_DBG_REG_RD   = 8'hE4;
  localparam logic [7:0] CMD_DBG_REG_WR   = 8'hC4;
  localparam logic [7:0] CMD_CPU_REG_RD   = 8'h68;
  localparam logic [7:0] CMD_CPU_REG_WR   = 8'h48;

  // Status byte answered in place of a memory access during wait
  localparam logic [7:0] STATUS_WAIT_ERR  = 8'hC1;
  localparam logic [7:0] STATUS_OK        = 8'h00;

  // ==========================================================================
  // Modes and command classes
  // ==========================================================================
  typedef enum logic [1:0] {
    OMC_RESET = 2'b00,
    OMC_RUN   = 2'b01,
    OMC_DEBUG = 2'b11,
    OMC_WAIT  = 2'b10
  } omc_mode_type;

  typedef enum logic [1:0] {
    CLS_NONE      = 2'b00,
    CLS_NONINTR   = 2'b01,
    CLS_STATUS    = 2'b10,
    CLS_ACTIVE    = 2'b11
  } omc_cls_type;

endpackage : omc_pkg

// >>> pkg/omc_cmd_if.sv
/*
  Carrier for decoded debug commands between the link receiver and the mode controller.
  Assumes a single clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
interface omc_cmd_if;
  logic       valid;
  logic [7:0] code;
  modport rx  (output valid, output code);
  modport ctl (input valid, input code);
endinterface : omc_cmd_if
`default_nettype wire

// >>> verilog/omc_rx.sv
/*
  Serial debug receiver: samples the debug line mid-bit and emits one command byte.
  Assumes the line is already synchronised to core_clk_i.
*/
`timescale 1ns/10ps
`default_nettype none
module omc_rx
  import omc_pkg::*;
(
  input  wire logic  core_clk_i,
  input  wire logic  nrst_i,
  input  wire logic  enable_i,
  input  wire logic  line_i,
  omc_cmd_if.rx      cmd
);

  logic [BIT_CNT_W-1:0]   bit_cnt;
  logic [FRAME_CNT_W-1:0] bit_idx;
  logic                   busy;
  logic                   line_d;
  logic [7:0]             shreg;

  // ==========================================================================
  // Bit timing
  // ==========================================================================
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      line_d <= 1'b1;
    end else begin
      line_d <= line_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      busy    <= 1'b0;
      bit_cnt <= '0;
      bit_idx <= '0;
    end else if (!busy) begin
      if (enable_i && line_d && !line_i) begin
        busy    <= 1'b1;
        bit_cnt <= '0;
        bit_idx <= '0;
      end
    end else begin
      bit_cnt <= bit_cnt + 1'b1;
      if (bit_cnt == BIT_CNT_W'(BIT_CYCLES - 1)) begin
        if (bit_idx == FRAME_CNT_W'(BITS_PER_FRAME - 1)) begin
          busy <= 1'b0;
        end
        bit_idx <= bit_idx + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Sampling and delivery
  // ==========================================================================
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      shreg     <= '0;
      cmd.valid <= 1'b0;
      cmd.code  <= '0;
    end else begin
      cmd.valid <= 1'b0;
      if (busy && bit_cnt == BIT_CNT_W'(BIT_CYCLES / 2)) begin
        shreg <= {shreg[6:0], line_i};
      end
      if (busy && bit_cnt == BIT_CNT_W'(BIT_CYCLES - 1)
          && bit_idx == FRAME_CNT_W'(BITS_PER_FRAME - 1)) begin
        cmd.valid <= 1'b1;
        cmd.code  <= shreg;
      end
    end
  end

endmodule : omc_rx
`default_nettype wire

// >>> verilog/omc_top.sv
/*
  Operating mode controller: run, active debug and wait modes, and debug command gating.
  Assumes a synchronous active-low reset, a force-reset flag from the core, and
  one-cycle event pulses from the processor and breakpoint logic.
*/
`timescale 1ns/10ps
`default_nettype none

module omc_top
  import omc_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        force_rst_i,
  input  wire logic        mode_select_debug_pin_i,
  input  wire logic        break_to_debug_instruction_i,
  input  wire logic        serial_debug_controller_bkpt_i,
  input  wire logic        on_chip_breakpoint_unit_bkpt_i,
  input  wire logic        wait_instr_i,
  input  wire logic        irq_i,
  output logic             mode_select_debug_pin_o,
  output logic             mode_select_debug_pin_oe_o,
  output logic [1:0]       mode_o,
  output logic             cpu_run_o,
  output logic             cpu_clk_en_o,
  output logic             sys_clk_en_o,
  output logic             full_reg_o,
  output logic             vec_fetch_o,
  output logic [15:0]      vec_addr_o,
  output logic             ccr_i_clear_o,
  output logic             irq_stack_o,
  output logic             cmd_exec_o,
  output logic [7:0]       cmd_code_o,
  output logic             mem_access_o,
  output logic             cmd_status_o,
  output logic [7:0]       status_o
);

  omc_cmd_if    cmd ();
  omc_mode_type mode;
  omc_mode_type next_mode;
  logic         pin_s1;
  logic         pin_s2;
  logic         force_s1;
  logic         force_s2;
  logic         was_reset;
  logic         strap_pending;
  logic         vec_step;
  logic         cmd_ok;
  omc_cls_type  cls;

  // ==========================================================================
  // Command classification
  // ==========================================================================
  function automatic omc_cls_type classify(input logic [7:0] code);
    unique case (code)
      CMD_MEM_READ_ST,
      CMD_MEM_WRITE_ST: classify = CLS_STATUS;
      CMD_BACKGROUND,
      CMD_MEM_READ,
      CMD_MEM_WRITE,
      CMD_DBG_REG_RD,
      CMD_DBG_REG_WR:   classify = CLS_NONINTR;
      CMD_CPU_REG_RD,
      CMD_CPU_REG_WR,
      CMD_TRACE,
      CMD_RESUME:       classify = CLS_ACTIVE;
      default:          classify = CLS_NONE;
    endcase
  endfunction : classify

  function automatic logic is_background(input logic [7:0] code);
    is_background = (code == CMD_BACKGROUND);
  endfunction : is_background

  // ==========================================================================
  // Pin and force reset synchronisers
  // ==========================================================================
  // Pin stages run through reset so the strap level stands at release
  always_ff @(posedge core_clk_i) begin
    pin_s1 <= mode_select_debug_pin_i;
    pin_s2 <= pin_s1;
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      force_s1 <= 1'b0;
      force_s2 <= 1'b0;
    end else begin
      force_s1 <= force_rst_i;
      force_s2 <= force_s1;
    end
  end

  // ==========================================================================
  // Serial receiver, enabled only outside reset
  // ==========================================================================
  omc_rx u_rx (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .enable_i   (mode != OMC_RESET),
    .line_i     (pin_s2),
    .cmd        (cmd)
  );

  // One decode of the received code serves run, debug and wait modes
  assign cls = classify(cmd.code);

  // ==========================================================================
  // Mode sequencing
  // ==========================================================================
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      strap_pending <= 1'b1;
      was_reset     <= 1'b1;
    end else begin
      strap_pending <= 1'b0;
      was_reset     <= 1'b0;
    end
  end

  always_comb begin
    next_mode = mode;
    unique case (mode)
      OMC_RESET: begin
        if (!strap_pending) begin
          next_mode = pin_s2 ? OMC_RUN : OMC_DEBUG;
        end
      end
      OMC_RUN: begin
        if (cmd.valid && is_background(cmd.code)) begin
          next_mode = OMC_DEBUG;
        end else if (break_to_debug_instruction_i) begin
          next_mode = OMC_DEBUG;
        end else if (serial_debug_controller_bkpt_i) begin
          next_mode = OMC_DEBUG;
        end else if (on_chip_breakpoint_unit_bkpt_i) begin
          next_mode = OMC_DEBUG;
        end else if (wait_instr_i) begin
          next_mode = OMC_WAIT;
        end
      end
      OMC_DEBUG: begin
        if (cmd.valid && cmd.code == CMD_RESUME) begin
          next_mode = OMC_RUN;
        end
      end
      OMC_WAIT: begin
        if (cmd.valid && is_background(cmd.code)) begin
          next_mode = OMC_DEBUG;
        end else if (irq_i) begin
          next_mode = OMC_RUN;
        end
      end
    endcase
    // Forced reset overrides every transition
    if (force_s2) begin
      next_mode = OMC_RESET;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      mode <= OMC_RESET;
    end else if (force_s2) begin
      mode <= OMC_RESET;
    end else begin
      mode <= next_mode;
    end
  end

  // ==========================================================================
  // Processor and clock controls
  // ==========================================================================
  // Mode shown to the core
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      mode_o <= OMC_RESET;
    end else begin
      mode_o <= next_mode;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      cpu_run_o    <= 1'b0;
      cpu_clk_en_o <= 1'b0;
      sys_clk_en_o <= 1'b1;
      full_reg_o   <= 1'b1;
    end else begin
      cpu_run_o    <= (next_mode == OMC_RUN) && !force_s2;
      cpu_clk_en_o <= (next_mode != OMC_WAIT);
      sys_clk_en_o <= 1'b1;
      full_reg_o   <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      ccr_i_clear_o <= 1'b0;
      irq_stack_o   <= 1'b0;
    end else begin
      ccr_i_clear_o <= (mode == OMC_RUN) && (next_mode == OMC_WAIT);
      irq_stack_o   <= (mode == OMC_WAIT) && (next_mode == OMC_RUN);
    end
  end

  // ==========================================================================
  // Reset vector fetch
  // ==========================================================================
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      vec_fetch_o <= 1'b0;
      vec_addr_o  <= VEC_HI_ADDR;
      vec_step    <= 1'b0;
    end else begin
      vec_fetch_o <= 1'b0;
      if (mode == OMC_RESET && next_mode == OMC_RUN) begin
        vec_fetch_o <= 1'b1;
        vec_addr_o  <= VEC_HI_ADDR;
        vec_step    <= 1'b1;
      end else if (vec_step) begin
        vec_fetch_o <= 1'b1;
        vec_addr_o  <= VEC_LO_ADDR;
        vec_step    <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Command gating
  // ==========================================================================
  always_comb begin
    cmd_ok = 1'b0;
    unique case (mode)
      OMC_RUN:   cmd_ok = (cls == CLS_NONINTR) || (cls == CLS_STATUS);
      OMC_DEBUG: cmd_ok = (cls != CLS_NONE);
      OMC_WAIT:  cmd_ok = (cls == CLS_STATUS) || is_background(cmd.code);
      OMC_RESET: cmd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      cmd_exec_o   <= 1'b0;
      cmd_code_o   <= '0;
      mem_access_o <= 1'b0;
      cmd_status_o <= 1'b0;
      status_o     <= STATUS_OK;
    end else begin
      cmd_exec_o   <= cmd.valid && cmd_ok;
      mem_access_o <= cmd.valid && cmd_ok && (mode != OMC_WAIT)
                      && (cls == CLS_STATUS || cmd.code == CMD_MEM_READ
                          || cmd.code == CMD_MEM_WRITE);
      cmd_status_o <= cmd.valid && cmd_ok && (cls == CLS_STATUS);
      if (cmd.valid) begin
        cmd_code_o <= cmd.code;
        status_o   <= (mode == OMC_WAIT) ? STATUS_WAIT_ERR : STATUS_OK;
      end
    end
  end

  // ==========================================================================
  // Debug pin drive: released (open drain pulled up) except never driven here
  // ==========================================================================
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      mode_select_debug_pin_o    <= 1'b0;
      mode_select_debug_pin_oe_o <= 1'b0;
    end else begin
      mode_select_debug_pin_o    <= 1'b0;
      mode_select_debug_pin_oe_o <= 1'b0;
    end
  end

  logic unused_was_reset;
  assign unused_was_reset = was_reset;

endmodule : omc_top
`default_nettype wire

// >>> sim/omc_host_model.sv
/*
  Debug host model driving the shared mode/debug line.
  Assumes the bench calls strap and send at a clock edge; line idles high by pull-up.
*/
`timescale 1ns/10ps
`default_nettype none
module omc_host_model (
  input  wire logic core_clk_i,
  output logic      line_o
);
  // =====================================
  // Strap level and serial frames
  // =====================================
  initial line_o = 1'b1;

  task automatic strap(input logic low);
    @(posedge core_clk_i) line_o <= !low;
  endtask : strap

  // Each bit: low 4 cycles, data until 13, high to 16
  task automatic send(input logic [7:0] c);
    @(posedge core_clk_i);
    for (int b = 7; b >= 0; b--) begin
      line_o <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      line_o <= c[b];
      repeat (9) @(posedge core_clk_i);
      line_o <= 1'b1;
      repeat (3) @(posedge core_clk_i);
    end
    repeat (16) @(posedge core_clk_i);
  endtask : send
endmodule : omc_host_model
`default_nettype wire

// >>> sim/omc_top_asserts.sv
/*
  Mode controller checker, bound to omc_top.
  Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module omc_asserts
  import omc_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        nrst_i,
  input wire logic        break_to_debug_instruction_i,
  input wire logic        serial_debug_controller_bkpt_i,
  input wire logic        on_chip_breakpoint_unit_bkpt_i,
  input wire logic        wait_instr_i,
  input wire logic        irq_i,
  input wire logic        mode_select_debug_pin_oe_o,
  input wire logic [1:0]  mode_o,
  input wire logic        cpu_run_o,
  input wire logic        cpu_clk_en_o,
  input wire logic        sys_clk_en_o,
  input wire logic        full_reg_o,
  input wire logic        vec_fetch_o,
  input wire logic [15:0] vec_addr_o,
  input wire logic        ccr_i_clear_o,
  input wire logic        irq_stack_o,
  input wire logic        cmd_exec_o,
  input wire logic        mem_access_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  logic brk;
  assign brk = break_to_debug_instruction_i | serial_debug_controller_bkpt_i
             | on_chip_breakpoint_unit_bkpt_i;
  // =====================================
  // Assertions
  // =====================================
  a_run_cpu_on: assert property (cpu_run_o == (mode_o == OMC_RUN))
    else $error("cpu run flag disagrees with mode");
  a_wait_clocks: assert property (mode_o == OMC_WAIT |->
    !cpu_clk_en_o && sys_clk_en_o && full_reg_o) else $error("wait clock gating wrong");
  a_wait_entry: assert property (mode_o == OMC_RUN && wait_instr_i && !brk
    |=> mode_o == OMC_WAIT && ccr_i_clear_o) else $error("wait entry wrong");
  a_break_debug: assert property (mode_o == OMC_RUN && brk
    |=> mode_o == OMC_DEBUG) else $error("break did not enter debug");
  a_irq_wake: assert property (mode_o == OMC_WAIT && irq_i
    |=> mode_o == OMC_RUN && irq_stack_o) else $error("interrupt did not end wait");
  a_vec_order: assert property (vec_fetch_o && vec_addr_o == VEC_HI_ADDR
    |=> vec_fetch_o && vec_addr_o == VEC_LO_ADDR) else $error("vector order wrong");
  a_run_fetch: assert property (mode_o == OMC_RUN && $past(mode_o) == OMC_RESET
    |-> ##[0:2] vec_fetch_o && vec_addr_o == VEC_HI_ADDR) else $error("no vector fetch");
  a_wait_no_mem: assert property (mode_o == OMC_WAIT |-> !mem_access_o)
    else $error("memory touched in wait");
  a_pin_released: assert property (!mode_select_debug_pin_oe_o)
    else $error("debug pin driven");
  c_wake: cover property (mode_o == OMC_WAIT ##1 mode_o == OMC_RUN);
  c_bkgd_wait: cover property (mode_o == OMC_WAIT ##1 mode_o == OMC_DEBUG);
  c_dbg_exec: cover property (cmd_exec_o && mode_o == OMC_DEBUG);
endmodule : omc_asserts
`default_nettype wire

// >>> sim/tb_operating_mode_control.sv
/*
  Self-checking bench for omc_top with a host model on the debug line.
  Assumes a 40 MHz clock and the command codes of omc_pkg.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb_operating_mode_control
  import omc_pkg::*;
;
  logic clk = 1'b0, nrst = 1'b0, frc = 1'b0, wt = 1'b0, irq = 1'b0;
  logic [2:0] ev = 3'h0;
  logic line, pin, pin_o, pin_oe, cpu_run, clk_en, sys_en, full_reg, vec_f, ccr_clr, stk;
  logic exec, mem, cst, s_exec, s_mem, s_ccr, s_stk, s_cst;
  logic [1:0] mode;
  logic [7:0] code, st, s_code;
  logic [15:0] vec_a, r;
  logic [15:0] vq[$];
  int n_mismatch = 0, samples_checked = 0;
  // Row: start mode, code, exec (2 = any), memory (2 = any), end mode (reset = any)
  logic [15:0] rows[21] = '{
    {OMC_RUN, CMD_MEM_READ, 2'h1, 2'h1, OMC_RUN}, {OMC_RUN, CMD_MEM_WRITE_ST, 2'h1, 2'h1, OMC_RUN},
    {OMC_RUN, CMD_DBG_REG_RD, 2'h1, 2'h2, OMC_RUN}, {OMC_RUN, CMD_DBG_REG_WR, 2'h1, 2'h2, OMC_RUN},
    {OMC_RUN, CMD_MEM_READ_ST, 2'h1, 2'h1, OMC_RUN}, {OMC_RUN, CMD_MEM_WRITE, 2'h1, 2'h1, OMC_RUN},
    {OMC_RUN, CMD_CPU_REG_RD, 2'h0, 2'h0, OMC_RUN}, {OMC_RUN, CMD_CPU_REG_WR, 2'h0, 2'h0, OMC_RUN},
    {OMC_RUN, CMD_TRACE, 2'h0, 2'h0, OMC_RUN}, {OMC_RUN, CMD_RESUME, 2'h0, 2'h0, OMC_RUN},
    {OMC_RUN, CMD_BACKGROUND, 2'h1, 2'h2, OMC_DEBUG},
    {OMC_DEBUG, CMD_CPU_REG_RD, 2'h1, 2'h2, OMC_DEBUG},
    {OMC_DEBUG, CMD_CPU_REG_WR, 2'h1, 2'h2, OMC_DEBUG},
    {OMC_DEBUG, CMD_TRACE, 2'h1, 2'h2, OMC_RESET}, {OMC_DEBUG, CMD_MEM_READ, 2'h1, 2'h1, OMC_DEBUG},
    {OMC_DEBUG, CMD_RESUME, 2'h1, 2'h2, OMC_RUN},
    {OMC_WAIT, CMD_MEM_WRITE_ST, 2'h1, 2'h0, OMC_WAIT},
    {OMC_WAIT, CMD_MEM_READ_ST, 2'h1, 2'h0, OMC_WAIT}, {OMC_WAIT, CMD_MEM_READ, 2'h0, 2'h0, OMC_WAIT},
    {OMC_WAIT, CMD_CPU_REG_WR, 2'h0, 2'h0, OMC_WAIT}, {OMC_WAIT, CMD_BACKGROUND, 2'h1, 2'h2, OMC_DEBUG}};

  always #12.5 clk = ~clk;
  assign pin = pin_oe ? pin_o : line;
  omc_host_model u_host (.core_clk_i(clk), .line_o(line));
  omc_top u_dut (.core_clk_i(clk), .nrst_i(nrst), .force_rst_i(frc), .mode_select_debug_pin_i(pin),
    .break_to_debug_instruction_i(ev[0]), .serial_debug_controller_bkpt_i(ev[1]),
    .on_chip_breakpoint_unit_bkpt_i(ev[2]), .wait_instr_i(wt), .irq_i(irq),
    .mode_select_debug_pin_o(pin_o), .mode_select_debug_pin_oe_o(pin_oe), .mode_o(mode),
    .cpu_run_o(cpu_run), .cpu_clk_en_o(clk_en), .sys_clk_en_o(sys_en), .full_reg_o(full_reg),
    .vec_fetch_o(vec_f), .vec_addr_o(vec_a), .ccr_i_clear_o(ccr_clr), .irq_stack_o(stk),
    .cmd_exec_o(exec), .cmd_code_o(code), .mem_access_o(mem), .cmd_status_o(cst), .status_o(st));

  // =====================================
  // Pulse monitor and tasks
  // =====================================
  always @(posedge clk) begin
    if (exec === 1'b1) begin
      s_exec = 1'b1;
      s_code = code;
    end
    if (mem === 1'b1) s_mem = 1'b1;
    if (ccr_clr === 1'b1) s_ccr = 1'b1;
    if (stk === 1'b1) s_stk = 1'b1;
    if (cst === 1'b1) s_cst = 1'b1;
    if (vec_f === 1'b1) vq.push_back(vec_a);
  end
  task automatic clr;
    {s_exec, s_mem, s_ccr, s_stk, s_cst} = 5'h0;
    vq.delete();
  endtask : clr
  task automatic rst(input logic low);
    u_host.strap(low);
    nrst <= 1'b0;
    clr();
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    u_host.strap(1'b0);
  endtask : rst
  task automatic pulse(input logic [2:0] e, input logic w, input logic q);
    ev <= e;
    wt <= w;
    irq <= q;
    @(posedge clk);
    {ev, wt, irq} <= 5'h0;
    repeat (2) @(posedge clk);
  endtask : pulse
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  // =====================================
  // Sequence
  // =====================================
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
  initial begin
    for (int i = 0; i < 21; i++) begin
      r = rows[i];
      rst(1'b0);
      if (r[15:14] != OMC_RUN) pulse({2'h0, r[15:14] == OMC_DEBUG}, r[15:14] == OMC_WAIT, 1'b0);
      clr();
      u_host.send(r[13:6]);
      repeat (4) @(posedge clk);
      if (r[5:4] != 2'h2) `CHK("exec", r[4], s_exec)
      if (r[3:2] != 2'h2) `CHK("mem", r[2], s_mem)
      if (s_exec === 1'b1) `CHK("code", r[13:6], s_code)
      if (r[13:6] == CMD_MEM_READ_ST || r[13:6] == CMD_MEM_WRITE_ST) begin
        `CHK("status", r[15:14] == OMC_WAIT ? STATUS_WAIT_ERR : STATUS_OK, st)
        `CHK("status flag", 1'b1, s_cst)
      end else `CHK("status flag", 1'b0, s_cst)
      if (r[1:0] != OMC_RESET) `CHK("mode", r[1:0], mode)
    end
    rst(1'b0);
    `CHK("run mode", OMC_RUN, mode)
    `CHK("vec count", 2, vq.size())
    `CHK("vec hi", VEC_HI_ADDR, vq[0])
    `CHK("vec lo", VEC_LO_ADDR, vq[1])
    rst(1'b1);
    `CHK("strap debug", OMC_DEBUG, mode)
    `CHK("suspended", 1'b0, cpu_run)
    for (int i = 0; i < 3; i++) begin
      rst(1'b0);
      pulse(3'(1 << i), 1'b0, 1'b0);
      `CHK("event debug", OMC_DEBUG, mode)
    end
    rst(1'b0);
    clr();
    pulse(3'h0, 1'b1, 1'b0);
    `CHK("wait mode", OMC_WAIT, mode)
    `CHK("cpu clock", 1'b0, clk_en)
    `CHK("sys clock", 1'b1, sys_en & full_reg)
    `CHK("mask clear", 1'b1, s_ccr)
    pulse(3'h0, 1'b0, 1'b1);
    `CHK("wake mode", OMC_RUN, mode)
    `CHK("stacking", 1'b1, s_stk)
    frc <= 1'b1;
    repeat (6) @(posedge clk);
    u_host.strap(1'b1);
    repeat (4) @(posedge clk);
    frc <= 1'b0;
    repeat (12) @(posedge clk);
    `CHK("forced debug", OMC_DEBUG, mode)
    `CHK("pin release", 2'h0, {pin_o, pin_oe})
    u_host.strap(1'b0);
    conclude();
  end
endmodule : tb_operating_mode_control
bind omc_top omc_asserts u_chk (
  .core_clk_i                     (core_clk_i),
  .nrst_i                         (nrst_i),
  .break_to_debug_instruction_i   (break_to_debug_instruction_i),
  .serial_debug_controller_bkpt_i (serial_debug_controller_bkpt_i),
  .on_chip_breakpoint_unit_bkpt_i (on_chip_breakpoint_unit_bkpt_i),
  .wait_instr_i                   (wait_instr_i),
  .irq_i                          (irq_i),
  .mode_select_debug_pin_oe_o     (mode_select_debug_pin_oe_o),
  .mode_o                         (mode_o),
  .cpu_run_o                      (cpu_run_o),
  .cpu_clk_en_o                   (cpu_clk_en_o),
  .sys_clk_en_o                   (sys_clk_en_o),
  .full_reg_o                     (full_reg_o),
  .vec_fetch_o                    (vec_fetch_o),
  .vec_addr_o                     (vec_addr_o),
  .ccr_i_clear_o                  (ccr_i_clear_o),
  .irq_stack_o                    (irq_stack_o),
  .cmd_exec_o                     (cmd_exec_o),
  .mem_access_o                   (mem_access_o)
);
`default_nettype wire
